// [design/flash_block_protection.sv]
// Flash array with per-pair read-only and execute-only protection
`timescale 1ns/1ps
module flash_block_protection
  import flash_prot_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Read port
  input  wire logic               rd_req,
  input  wire rd_src_t            rd_src,
  input  wire logic [WADDR_W-1:0] rd_addr,
  output logic                    rd_valid,
  output logic [31:0]             rd_data,
  output logic                    rd_err,
  // Program port
  input  wire logic               pgm_req,
  input  wire logic [WADDR_W-1:0] pgm_addr,
  input  wire logic [31:0]        pgm_data,
  // Erase port
  input  wire logic               ers_req,
  input  wire logic [BLK_W-1:0]   ers_blk,
  output logic                    busy,
  // Protection setting
  input  wire logic               prot_set,
  input  wire logic [PAIR_W-1:0]  prot_pair,
  input  wire logic               prot_ro,
  input  wire logic               prot_xo,
  // Violation status
  input  wire logic               viol_clr,
  output logic                    viol
);
  typedef enum logic {ST_IDLE, ST_ERASE} state_t;

  logic [31:0]        mem [WORDS];
  state_t             state_r;
  state_t             state_nxt;
  logic [BWORD_W-1:0] ecnt_r;
  logic [BLK_W-1:0]   eblk_r;
  logic               rd_valid_r;
  logic [31:0]        rd_data_r;
  logic               rd_err_r;
  logic               viol_r;
  logic [PAIRS-1:0]   ro_v;
  logic [PAIRS-1:0]   xo_v;
  logic [PAIRS-1:0]   mod_ok_v;

  ////////////////////////////////////////////////////////////////////////
  // One guard per 2 KB pair
  genvar g;
  for (g = 0; g < PAIRS; g++) begin : g_pair
    flash_pair_guard u_guard (
      .clk       (clk),
      .arst_n    (arst_n),
      .set_en    (prot_set && (prot_pair == PAIR_W'(g))),
      .ro_in     (prot_ro),
      .xo_in     (prot_xo),
      .ro        (ro_v[g]),
      .xo        (xo_v[g]),
      .modify_ok (mod_ok_v[g])
    );
  end

  // Address slicing needs whole pairs and power-of-two word and block counts
  if ((BLOCKS % PAIR_BLOCKS != 0) || ((1 << WADDR_W) != WORDS)
      || ((1 << BLK_W) != BLOCKS)) begin : g_geom_bad
    $error("flash geometry cannot be served by the address slicing");
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode of pair indices and permission checks
  wire [PAIR_W-1:0] rd_pair  = rd_addr[WADDR_W-1 -: PAIR_W];
  wire [PAIR_W-1:0] pgm_pair = pgm_addr[WADDR_W-1 -: PAIR_W];
  wire [PAIR_W-1:0] ers_pair = ers_blk[BLK_W-1 -: PAIR_W];
  wire idle      = (state_r == ST_IDLE);
  wire rd_deny   = xo_v[rd_pair] && (rd_src != SRC_FETCH); // R8
  wire rd_ok     = rd_req && !rd_deny;
  wire pgm_deny  = !mod_ok_v[pgm_pair]; // R6 R7
  wire ers_deny  = !mod_ok_v[ers_pair]; // R6 R7
  wire ers_start = idle && ers_req && !ers_deny;
  wire pgm_do    = idle && !ers_req && pgm_req && !pgm_deny;
  wire viol_ev   = (rd_req && rd_deny) || (idle && ers_req && ers_deny)
                 || (idle && !ers_req && pgm_req && pgm_deny); // R9
  wire [WADDR_W-1:0] ers_addr = {eblk_r, ecnt_r};
  wire ers_last  = (ecnt_r == BWORD_W'(ERASE_CYCLES - 1));

  assign busy = !idle;

  // Erase sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (ers_start) state_nxt = ST_ERASE;
      ST_ERASE: if (ers_last) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      ecnt_r  <= '0;
      eblk_r  <= '0;
    end else begin
      state_r <= state_nxt;
      ecnt_r  <= ers_start ? '0 : ecnt_r + 1'b1;
      if (ers_start) eblk_r <= ers_blk; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array writes: erase fills a block with ones, program stores a word
  always_ff @(posedge clk) begin
    if (state_r == ST_ERASE) mem[ers_addr] <= ERASED_WORD; // R3
    else if (pgm_do) mem[pgm_addr] <= pgm_data;
  end

  // Single-cycle read path; denied reads return zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
      rd_err_r   <= 1'b0;
    end else begin
      rd_valid_r <= rd_req; // R1
      rd_err_r   <= rd_req && rd_deny; // R8
      rd_data_r  <= rd_ok ? mem[rd_addr] : 32'h00000000; // R1
    end
  end

  // Sticky violation flag; a new event wins over a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) viol_r <= 1'b0;
    else if (viol_ev) viol_r <= 1'b1; // R9
    else if (viol_clr) viol_r <= 1'b0;
  end

  assign rd_valid = rd_valid_r;
  assign rd_data  = rd_data_r;
  assign rd_err   = rd_err_r;
  assign viol     = viol_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rd_latency;
    @(posedge clk) disable iff (!arst_n) rd_req |=> rd_valid;
  endproperty
  a_rd_latency: assert property (p_rd_latency) // R1
    else $error("read not answered in one cycle");

  property p_xo_deny;
    @(posedge clk) disable iff (!arst_n)
      rd_req && xo_v[rd_pair] && rd_src != SRC_FETCH
      |=> rd_err && rd_data == 32'h00000000;
  endproperty
  a_xo_deny: assert property (p_xo_deny) // R8
    else $error("execute-only data read not refused");

  property p_fetch_ok;
    @(posedge clk) disable iff (!arst_n)
      rd_req && rd_src == SRC_FETCH |=> !rd_err;
  endproperty
  a_fetch_ok: assert property (p_fetch_ok) // R8
    else $error("fetch wrongly refused");

  property p_viol_set;
    @(posedge clk) disable iff (!arst_n) viol_ev |=> viol;
  endproperty
  a_viol_set: assert property (p_viol_set) // R9
    else $error("violation flag not raised");

  property p_pgm_block;
    @(posedge clk) disable iff (!arst_n)
      pgm_req && ro_v[pgm_pair] |-> !pgm_do;
  endproperty
  a_pgm_block: assert property (p_pgm_block) // R6
    else $error("program into protected pair");

  property p_ers_block;
    @(posedge clk) disable iff (!arst_n)
      idle && ers_req && (ro_v[ers_pair] || xo_v[ers_pair]) |=> idle;
  endproperty
  a_ers_block: assert property (p_ers_block) // R7
    else $error("erase of protected pair started");

  property p_ers_len;
    @(posedge clk) disable iff (!arst_n)
      ers_start |=> busy ##256 !busy;
  endproperty
  a_ers_len: assert property (p_ers_len) // R2
    else $error("erase length wrong");

  property p_ers_fill;
    @(posedge clk) disable iff (!arst_n)
      state_r == ST_ERASE |=> mem[$past(ers_addr)] == ERASED_WORD;
  endproperty
  a_ers_fill: assert property (p_ers_fill) // R3
    else $error("erased word not all ones");

  property p_prot_ind;
    @(posedge clk) disable iff (!arst_n)
      prot_set |=> ro_v[$past(prot_pair)] == $past(prot_ro);
  endproperty
  a_prot_ind: assert property (p_prot_ind) // R4
    else $error("pair protection not stored");

  property p_pgm_xo;
    @(posedge clk) disable iff (!arst_n)
      pgm_req && xo_v[pgm_pair] |-> !pgm_do;
  endproperty
  a_pgm_xo: assert property (p_pgm_xo) // R7
    else $error("program into execute-only pair");

  property p_ers_ro;
    @(posedge clk) disable iff (!arst_n)
      idle && ers_req && ro_v[ers_pair] |=> idle && viol;
  endproperty
  a_ers_ro: assert property (p_ers_ro) // R6
    else $error("erase of read-only pair not refused");

  property p_viol_clr;
    @(posedge clk) disable iff (!arst_n)
      viol_clr && !viol_ev |=> !viol;
  endproperty
  a_viol_clr: assert property (p_viol_clr) // R9
    else $error("violation flag not cleared");
endmodule

// [design/flash_prot_pkg.sv]
// Constants and types shared by the flash protection block
// Summary of operation
// R1: Flash reads return data one clock after the request, every cycle.
// R2: Array holds 128 KB, split into 1 KB blocks erased one by one.
// R3: An erased block reads back as all ones.
// R4: Protection is set per 2 KB pair of adjacent blocks, each independent.
// R5: Each pair can be marked read-only or execute-only.
// R6: Read-only pairs refuse every erase and program request.
// R7: Execute-only pairs also refuse every erase and program request.
// R8: Execute-only pairs answer fetches only; data and debug reads refused.
// R9: A refused access leaves contents untouched and sets a violation flag; code flags refused erases and programs only while idle.
package flash_prot_pkg;
  localparam int unsigned FLASH_BYTES  = 131072;
  localparam int unsigned BLOCK_BYTES  = 1024;
  localparam int unsigned PAIR_BLOCKS  = 2;
  localparam int unsigned WORD_BYTES   = 4;
  localparam int unsigned WORDS        = FLASH_BYTES / WORD_BYTES;
  localparam int unsigned BLOCKS       = FLASH_BYTES / BLOCK_BYTES;
  localparam int unsigned PAIRS        = BLOCKS / PAIR_BLOCKS;
  localparam int unsigned WADDR_W      = $clog2(WORDS);
  localparam int unsigned BWORD_W      = $clog2(BLOCK_BYTES / WORD_BYTES);
  localparam int unsigned BLK_W        = $clog2(BLOCKS);
  localparam int unsigned PAIR_W       = $clog2(PAIRS);
  localparam int unsigned ERASE_CYCLES = BLOCK_BYTES / WORD_BYTES;
  localparam logic [31:0] ERASED_WORD  = 32'hFFFFFFFF;
  // Reads: instruction fetch, data bus, debugger
  typedef enum logic [1:0] {SRC_FETCH, SRC_DATA, SRC_DEBUG} rd_src_t;
endpackage

// [design/flash_pair_guard.sv]
// Protection state and checks for one 2 KB pair
`timescale 1ns/1ps
module flash_pair_guard
  import flash_prot_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Protection setting
  input  wire logic set_en,
  input  wire logic ro_in,
  input  wire logic xo_in,
  // Checks
  output logic      ro,
  output logic      xo,
  output logic      modify_ok
);
  logic ro_r;
  logic xo_r;

  // Per-pair protection bits, independent of every other pair
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ro_r <= 1'b0;
      xo_r <= 1'b0;
    end else if (set_en) begin // R4
      ro_r <= ro_in; // R5
      xo_r <= xo_in; // R5
    end
  end

  assign ro        = ro_r;
  assign xo        = xo_r;
  assign modify_ok = !ro_r && !xo_r; // R6 R7
endmodule

// [bench/cpu_port.sv]
// Processor side model driving the flash read port
`timescale 1ns/1ps
module cpu_port
  import flash_prot_pkg::*;
(
  // Request from the bench
  input  wire logic               go,
  input  wire rd_src_t            src,
  input  wire logic [WADDR_W-1:0] addr,
  // Read port of the flash block
  output logic                    rd_req,
  output rd_src_t                 rd_src,
  output logic [WADDR_W-1:0]      rd_addr
);
  // Idle address shows the inverse so a stale value never matches
  assign rd_req  = go;
  assign rd_src  = src;
  assign rd_addr = go ? addr : ~addr;
endmodule

// [bench/flash_block_protection_tb.sv]
// Self-checking bench for the flash protection block
`timescale 1ns/1ps
module flash_block_protection_tb
  import flash_prot_pkg::*;
;
  typedef struct {rd_src_t s; logic [14:0] a; logic [31:0] d; logic e;} row_t;
  logic clk = 0, arst_n = 0, go = 0, pgm_req = 0, ers_req = 0;
  logic prot_set = 0, prot_ro = 0, prot_xo = 0, viol_clr = 0;
  rd_src_t src = SRC_FETCH, rd_src;
  logic [WADDR_W-1:0] addr = '0, pgm_addr = '0, rd_addr;
  logic [31:0] pgm_data = '0, rd_data;
  logic [BLK_W-1:0] ers_blk = '0;
  logic [PAIR_W-1:0] prot_pair = '0;
  logic rd_req, rd_valid, rd_err, busy, viol;
  int bad_count = 0, compares = 0, n;
  row_t rows [6];
  // Clock and hang guard
  always #12.5 clk = ~clk;
  initial begin
    #(25 * 5000);
    bad_count++;
    give_verdict();
  end
  cpu_port i_cpu_port (.go(go), .src(src), .addr(addr), .rd_req(rd_req),
    .rd_src(rd_src), .rd_addr(rd_addr));
  flash_block_protection i_flash_block_protection (.clk(clk),
    .arst_n(arst_n), .rd_req(rd_req), .rd_src(rd_src), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_err(rd_err),
    .pgm_req(pgm_req), .pgm_addr(pgm_addr), .pgm_data(pgm_data),
    .ers_req(ers_req), .ers_blk(ers_blk), .busy(busy),
    .prot_set(prot_set), .prot_pair(prot_pair), .prot_ro(prot_ro),
    .prot_xo(prot_xo), .viol_clr(viol_clr), .viol(viol));
  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per result kind
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  // Port cycles: request at one edge, lowered at the next
  task automatic rd(input rd_src_t s, input logic [WADDR_W-1:0] a);
    @(posedge clk);
    go   <= 1'b1;
    src  <= s;
    addr <= a;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask
  task automatic pgm(input logic [WADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    pgm_req  <= 1'b1;
    pgm_addr <= a;
    pgm_data <= d;
    @(posedge clk);
    pgm_req <= 1'b0;
    #1;
  endtask
  task automatic ers(input logic [BLK_W-1:0] b);
    @(posedge clk);
    ers_req <= 1'b1;
    ers_blk <= b;
    @(posedge clk);
    ers_req <= 1'b0;
    #1;
  endtask
  task automatic prot(input logic [PAIR_W-1:0] p, input logic r,
                      input logic x);
    @(posedge clk);
    prot_set  <= 1'b1;
    prot_pair <= p;
    prot_ro   <= r;
    prot_xo   <= x;
    @(posedge clk);
    prot_set <= 1'b0;
    #1;
  endtask
  task automatic clr();
    @(posedge clk);
    viol_clr <= 1'b1;
    @(posedge clk);
    viol_clr <= 1'b0;
    #1;
  endtask
  // Refused modify: no erase started, violation raised, then cleared
  task automatic refused();
    chk1(busy, 1'b0);
    chk1(viol, 1'b1);
    clr();
  endtask
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rows[0] = '{SRC_FETCH, 15'h0000, 32'hFFFFFFFF, 1'b0};
    rows[1] = '{SRC_DATA,  15'h0100, 32'h12345678, 1'b0};
    rows[2] = '{SRC_DEBUG, 15'h0200, 32'h5A5A5A5A, 1'b0};
    rows[3] = '{SRC_FETCH, 15'h0400, 32'hA5A5A5A5, 1'b0};
    rows[4] = '{SRC_DATA,  15'h0400, 32'h00000000, 1'b1};
    rows[5] = '{SRC_DEBUG, 15'h0400, 32'h00000000, 1'b1};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk1(busy, 1'b0);
    chk1(viol, 1'b0);
    $display("test reset done");
    pgm(15'h0000, 32'h00000000);
    pgm(15'h0100, 32'h12345678);
    pgm(15'h0200, 32'h5A5A5A5A);
    pgm(15'h0400, 32'hA5A5A5A5);
    ers(7'h00);
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk1(n == 256, 1'b1);
    rd(SRC_DATA, 15'h00FF);
    chk32(rd_data, ERASED_WORD);
    $display("test erase done");
    prot(6'h01, 1'b1, 1'b0);
    prot(6'h02, 1'b0, 1'b1);
    foreach (rows[i]) begin
      rd(rows[i].s, rows[i].a);
      chk1(rd_valid, 1'b1);
      chk32(rd_data, rows[i].d);
      chk1(rd_err, rows[i].e);
    end
    chk1(viol, 1'b1);
    clr();
    chk1(viol, 1'b0);
    chk1(rd_valid, 1'b0);
    $display("test read table done");
    pgm(15'h0200, 32'h00000000);
    refused();
    ers(7'h02);
    refused();
    pgm(15'h0400, 32'h00000000);
    refused();
    ers(7'h05);
    refused();
    rd(SRC_FETCH, 15'h0200);
    chk32(rd_data, 32'h5A5A5A5A);
    rd(SRC_FETCH, 15'h0400);
    chk32(rd_data, 32'hA5A5A5A5);
    pgm(15'h0001, 32'hC3C3C3C3);
    rd(SRC_DATA, 15'h0001);
    chk32(rd_data, 32'hC3C3C3C3);
    $display("test refusals done");
    // Mid-run reset clears protection and status, the array keeps its words
    pgm(15'h0200, 32'h00000000);
    chk1(viol, 1'b1);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk1(viol, 1'b0);
    chk1(busy, 1'b0);
    rd(SRC_DATA, 15'h0400);
    chk32(rd_data, 32'hA5A5A5A5);
    pgm(15'h0200, 32'h3C3C3C3C);
    rd(SRC_DATA, 15'h0200);
    chk32(rd_data, 32'h3C3C3C3C);
    chk1(viol, 1'b0);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
